// file: design/mcct_noise_filter.sv
// Glitch filter for the selected capture input.
// Assumes din is synchronous to clk; sample_en is high on every cycle that takes a sample.
`timescale 1ns/10ps
`default_nettype none

module mcct_noise_filter #(
  parameter int HIST_W = mcct_pkg::FILT_LONG
) (
  input  wire logic clk,          // System clock
  input  wire logic reset_n,      // Synchronous reset, active low
  input  wire logic active,       // Filter in use
  input  wire logic sample_en,    // Sample strobe
  input  wire logic four_samples, // 1: four equal samples, 0: two
  input  wire logic din,          // Raw level
  output var  logic dout          // Accepted level
);

  typedef struct packed {
    logic [HIST_W-1:0] hist;
    logic              lvl;
  } mcct_filt_s;

  mcct_filt_s filt_reg;
  mcct_filt_s filt_next;

  always_comb begin
    filt_next = filt_reg;
    if (!active) begin
      // Bypass: follow the input, keep history primed with it
      filt_next.hist = {HIST_W{din}};
      filt_next.lvl  = din;
    end else if (sample_en) begin
      filt_next.hist = {filt_reg.hist[HIST_W-2:0], din};
      if (four_samples) begin
        if (&filt_next.hist) filt_next.lvl = 1'b1;      // [RQ9]
        if (~|filt_next.hist) filt_next.lvl = 1'b0;     // [RQ9]
      end else begin
        if (&filt_next.hist[mcct_pkg::FILT_SHORT-1:0]) begin
          filt_next.lvl = 1'b1;                         // [RQ9]
        end
        if (~|filt_next.hist[mcct_pkg::FILT_SHORT-1:0]) begin
          filt_next.lvl = 1'b0;                         // [RQ9]
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      filt_reg <= '0;
    end else begin
      filt_reg <= filt_next;
    end
  end

  assign dout = filt_reg.lvl;

endmodule // mcct_noise_filter
`default_nettype wire

// file: design/mcct_timer.sv
// Motor capture/compare timer: 16-bit up-counter with capture and compare.
// Assumes all inputs synchronous to clk and an Avalon-MM master.
//
// What this block does
// [RQ1] 16-bit counter advances on selected clock when enabled
// [RQ2] Counter compared on each count tick against 16-bit compare value
// [RQ3] Clock select: PWM signal or sysclk/2 to /128
// [RQ4] Pause bit holds counter; clearing resumes from there
// [RQ5] Switch on zeroes counter; switch off keeps value
// [RQ6] Source select: Hall A, B, C or external pin
// [RQ7] Edge select: off, rising, falling or both
// [RQ8] Captures accepted only while capture input enabled
// [RQ9] Filter needs two or four equal samples
// [RQ10] Filter samples at sysclk or sysclk/4
// [RQ11] Filter works only when module on and enabled
// [RQ12] Capture auto-clear: copy counter, then clear it
// [RQ13] Compare auto-clear zeroes counter on every match
// [RQ14] Compare value zero still matches with auto-clear
// [RQ15] Live counter readable as two read-only bytes
// [RQ16] Every valid capture copies counter to capture pair
// [RQ17] Counter overflow sets overflow flag, except when a compare auto-clear match happens at all-ones
// [RQ18] Compare equality sets compare flag
// [RQ19] Overflow wraps all-ones to zero, keeps counting
`timescale 1ns/10ps
`default_nettype none

module mcct_timer #(
  parameter int CNT_W = mcct_pkg::CNT_W,
  parameter int PRE_W = mcct_pkg::PRE_W
) (
  input  wire logic                          clk,                // System clock
  input  wire logic                          reset_n,            // Sync reset, low
  input  wire logic [mcct_pkg::ADDR_W-1:0]   avs_address,        // Byte address
  input  wire logic                          avs_read,           // Read request
  input  wire logic                          avs_write,          // Write request
  input  wire logic [mcct_pkg::DATA_W-1:0]   avs_writedata,      // Write data
  input  wire logic [3:0]                    avs_byteenable,     // Byte lanes
  output var  logic [mcct_pkg::DATA_W-1:0]   avs_readdata,       // Read data
  output var  logic                          avs_waitrequest,    // Stall
  input  wire logic                          pwm_period_signal,  // PWM count clock
  input  wire mcct_pkg::mcct_cap_in_s        cap_in,             // Capture inputs
  output var  logic                          overflow_flag,      // Counter wrapped
  output var  logic                          compare_match_flag  // Compare hit
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    mcct_pkg::mcct_ctrl_a_s       ctrl_a;
    mcct_pkg::mcct_ctrl_b_s       ctrl_b;
    logic [CNT_W-1:0]             cmp;
    logic [CNT_W-1:0]             cnt;
    logic [CNT_W-1:0]             capt;
    logic                         ovf;
    logic                         cmpf;
    logic [PRE_W-1:0]             pre;
    logic [1:0]                   fdiv;
    logic                         on_d;
    logic                         pwm_d;
    logic                         cap_d;
    logic                         wait_;
    logic [mcct_pkg::DATA_W-1:0]  rdata;
  } mcct_state_s;

  mcct_state_s st_reg;
  mcct_state_s st_next;

  logic cap_raw;
  logic cap_lvl;
  logic filt_active;
  logic filt_sample;
  logic tick;
  logic run;
  logic cap_rise;
  logic cap_fall;
  logic cap_hit;
  logic cmp_hit;
  logic wr_take;
  logic rd_take;
  logic clr_ovf;
  logic clr_cmp;
  logic [7:0] wbyte;

  // ****************************************
  // Helpers
  // ****************************************
  // Ones in the low sel bits: the prescaler phase that ends a 2^sel period
  function automatic logic [PRE_W-1:0] div_mask(input logic [2:0] sel);
    logic [PRE_W-1:0] m;
    m = '0;
    for (int i = 0; i < PRE_W; i++) begin
      m[i] = (i < int'(sel));
    end
    return m;
  endfunction

  function automatic logic [mcct_pkg::DATA_W-1:0] byte_word(input logic [7:0] b);
    return {{(mcct_pkg::DATA_W-8){1'b0}}, b};
  endfunction

  // ****************************************
  // Capture source and filter
  // ****************************************
  always_comb begin
    case (st_reg.ctrl_a.capture_source_select)                  // [RQ6]
      mcct_pkg::SRC_HALL_A:  cap_raw = cap_in.hall_input_a;
      mcct_pkg::SRC_HALL_B:  cap_raw = cap_in.hall_input_b;
      mcct_pkg::SRC_HALL_C:  cap_raw = cap_in.hall_input_c;
      mcct_pkg::SRC_EXT_PIN: cap_raw = cap_in.external_capture_pin;
      default:               cap_raw = 1'b0;
    endcase
  end

  assign filt_active = st_reg.ctrl_a.module_on
                     & st_reg.ctrl_b.filter_enable;              // [RQ11]
  assign filt_sample = ~st_reg.ctrl_b.filter_clock_select
                     | (st_reg.fdiv == mcct_pkg::FILT_DIV_END);  // [RQ10]

  mcct_noise_filter #(
    .HIST_W (mcct_pkg::FILT_LONG)
  ) u_filter (
    .clk          (clk),
    .reset_n      (reset_n),
    .active       (filt_active),
    .sample_en    (filt_sample),
    .four_samples (st_reg.ctrl_b.filter_sample_count),
    .din          (cap_raw),
    .dout         (cap_lvl)
  );

  // ****************************************
  // Events
  // ****************************************
  always_comb begin
    if (st_reg.ctrl_a.count_clock_select == mcct_pkg::CLK_SEL_PWM) begin
      tick = pwm_period_signal & ~st_reg.pwm_d;                  // [RQ3]
    end else begin
      tick = &(st_reg.pre | ~div_mask(st_reg.ctrl_a.count_clock_select)); // [RQ3]
    end
  end

  assign run = st_reg.ctrl_a.module_on & st_reg.on_d
             & ~st_reg.ctrl_a.counter_pause & tick;              // [RQ1] [RQ4]

  assign cap_rise = cap_lvl & ~st_reg.cap_d;
  assign cap_fall = ~cap_lvl & st_reg.cap_d;

  always_comb begin
    case (st_reg.ctrl_b.capture_edge_select)                    // [RQ7]
      mcct_pkg::EDGE_RISE: cap_hit = cap_rise;
      mcct_pkg::EDGE_FALL: cap_hit = cap_fall;
      mcct_pkg::EDGE_BOTH: cap_hit = cap_rise | cap_fall;
      default:             cap_hit = 1'b0;
    endcase
    // Module must be on and already running past its switch-on cycle
    cap_hit = cap_hit & st_reg.ctrl_b.capture_input_enable    // [RQ8]
            & st_reg.ctrl_a.module_on & st_reg.on_d;
  end

  // Match is judged on a count tick so a held value does not re-fire
  assign cmp_hit = run & (st_reg.cnt == st_reg.cmp);            // [RQ2] [RQ14]

  // ****************************************
  // Bus decode
  // ****************************************
  assign wr_take = avs_write & ~st_reg.wait_;
  assign rd_take = avs_read & st_reg.wait_;
  assign wbyte   = avs_writedata[7:0];
  assign clr_ovf = wr_take & avs_byteenable[0]
                 & (avs_address == mcct_pkg::OFS_FLAGS)
                 & wbyte[mcct_pkg::FLAG_OVF_BIT];
  assign clr_cmp = wr_take & avs_byteenable[0]
                 & (avs_address == mcct_pkg::OFS_FLAGS)
                 & wbyte[mcct_pkg::FLAG_CMP_BIT];

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    st_next       = st_reg;
    st_next.on_d  = st_reg.ctrl_a.module_on;
    st_next.pwm_d = pwm_period_signal;
    st_next.cap_d = cap_lvl;

    // The count prescaler runs only while the module is on to save toggling; fdiv always runs
    if (st_reg.ctrl_a.module_on) begin
      st_next.pre = st_reg.pre + PRE_W'(1);
    end else begin
      st_next.pre = '0;
    end
    st_next.fdiv = st_reg.fdiv + 2'h1;

    // Counter: switch-on clear first, then count, compare, capture
    if (st_reg.ctrl_a.module_on & ~st_reg.on_d) begin
      st_next.cnt = '0;                                         // [RQ5]
      st_next.pre = '0;
    end else begin
      if (run) begin
        st_next.cnt = st_reg.cnt + CNT_W'(1);                   // [RQ1] [RQ19]
        if (&st_reg.cnt) begin
          st_next.ovf = 1'b1;                                   // [RQ17]
        end
      end
      if (cmp_hit) begin
        st_next.cmpf = 1'b1;                                    // [RQ18] [RQ14]
        if (st_reg.ctrl_b.compare_auto_clear) begin
          st_next.cnt = '0;                                     // [RQ13]
          st_next.ovf = st_reg.ovf | (&st_reg.cnt & ~(&st_reg.cmp));
        end
      end
      if (cap_hit) begin
        st_next.capt = st_reg.cnt;                              // [RQ16] [RQ12]
        if (st_reg.ctrl_b.capture_auto_clear) begin
          st_next.cnt = '0;                                     // [RQ12]
        end
      end
    end

    // Bus: waitrequest drops one cycle after a request arrives
    st_next.wait_ = ~((avs_read | avs_write) & st_reg.wait_);
    if (rd_take) begin
      case (avs_address)
        mcct_pkg::OFS_CTRL_A: begin
          st_next.rdata = byte_word({st_reg.ctrl_a[7:3], 1'b0, st_reg.ctrl_a[1:0]});
        end
        mcct_pkg::OFS_CTRL_B: begin
          st_next.rdata = byte_word(st_reg.ctrl_b);
        end
        mcct_pkg::OFS_CNT_LO: begin
          st_next.rdata = byte_word(st_reg.cnt[7:0]);            // [RQ15]
        end
        mcct_pkg::OFS_CNT_HI: begin
          st_next.rdata = byte_word(st_reg.cnt[15:8]);           // [RQ15]
        end
        mcct_pkg::OFS_CMP_LO: begin
          st_next.rdata = byte_word(st_reg.cmp[7:0]);
        end
        mcct_pkg::OFS_CMP_HI: begin
          st_next.rdata = byte_word(st_reg.cmp[15:8]);
        end
        mcct_pkg::OFS_CAPT_LO: begin
          st_next.rdata = byte_word(st_reg.capt[7:0]);
        end
        mcct_pkg::OFS_CAPT_HI: begin
          st_next.rdata = byte_word(st_reg.capt[15:8]);
        end
        mcct_pkg::OFS_FLAGS: begin
          st_next.rdata = byte_word({6'h00, st_reg.cmpf, st_reg.ovf});
        end
        default: begin
          st_next.rdata = '0;
        end
      endcase
    end

    if (wr_take & avs_byteenable[0]) begin
      case (avs_address)
        mcct_pkg::OFS_CTRL_A: begin
          st_next.ctrl_a          = wbyte;                       // [RQ3] [RQ4] [RQ5]
          st_next.ctrl_a.reserved = 1'b0;
        end
        mcct_pkg::OFS_CTRL_B: begin
          st_next.ctrl_b = wbyte;                               // [RQ7] [RQ8]
        end
        mcct_pkg::OFS_CMP_LO: begin
          st_next.cmp[7:0] = wbyte;                             // [RQ2]
        end
        mcct_pkg::OFS_CMP_HI: begin
          st_next.cmp[15:8] = wbyte;                            // [RQ2]
        end
        default: begin
        end
      endcase
    end

    // A flag set in the clearing cycle survives the clear
    if (clr_ovf & ~(st_next.ovf & ~st_reg.ovf)) begin
      st_next.ovf = 1'b0;
    end
    if (clr_cmp & ~(st_next.cmpf & ~st_reg.cmpf)) begin
      st_next.cmpf = 1'b0;
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      st_reg        <= '0;
      st_reg.ctrl_a <= mcct_pkg::CTRL_A_RST;
      st_reg.ctrl_b <= mcct_pkg::CTRL_B_RST;
      st_reg.wait_  <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign avs_readdata       = st_reg.rdata;
  assign avs_waitrequest    = st_reg.wait_;
  assign overflow_flag      = st_reg.ovf;
  assign compare_match_flag = st_reg.cmpf;

endmodule // mcct_timer
`default_nettype wire

// file: dv/mcct_hall_model.sv
// Partner model: Hall lines, external capture pin and PWM period pulses.
// Assumes the bench changes level, pulses and go just after rising edges.
`timescale 1ns/10ps
`default_nettype none

module mcct_hall_model (
  input  wire logic                   clk,    // System clock
  input  wire logic [3:0]             level,  // Wanted line levels
  input  wire logic [7:0]             pulses, // PWM pulses per burst
  input  wire logic                   go,     // Start a burst
  output var  logic                   busy,   // Burst running
  output var  mcct_pkg::mcct_cap_in_s cap_in, // Lines to the timer
  output var  logic                   pwm     // PWM period signal
);
  // Four clocks per pulse; the signal stands low between bursts
  logic [9:0] phase_reg = '0;
  always_ff @(posedge clk) begin
    cap_in <= level;
    if (go) begin
      phase_reg <= {pulses, 2'h0};
    end else if (phase_reg != '0) begin
      phase_reg <= phase_reg - 10'h1;
    end
  end
  assign busy = (phase_reg != '0);
  assign pwm  = phase_reg[1];
endmodule // mcct_hall_model
`default_nettype wire

// file: dv/mcct_timer_checker.sv
// Checker: register handshake and flag assertions on the timer's ports.
// Assumes it is bound into mcct_timer; one clock, synchronous reset.
`timescale 1ns/10ps
`default_nettype none

module mcct_timer_checker (
  input wire logic        clk,               // System clock
  input wire logic        reset_n,           // Sync reset, low
  input wire logic [5:0]  avs_address,       // Byte address
  input wire logic        avs_read,          // Read request
  input wire logic        avs_write,         // Write request
  input wire logic [31:0] avs_writedata,     // Write data
  input wire logic [31:0] avs_readdata,      // Read data
  input wire logic        avs_waitrequest,   // Stall
  input wire logic        overflow_flag,     // Counter wrapped
  input wire logic        compare_match_flag // Compare hit
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  logic clr;
  // A completing write of the flag register may clear a flag
  assign clr = avs_write && !avs_waitrequest && avs_address == mcct_pkg::OFS_FLAGS;

  // ****************************************
  // Assertions
  // ****************************************
  reset_idle_a: assert property (disable iff (1'b0)
    !reset_n |=> avs_waitrequest && !overflow_flag && !compare_match_flag && avs_readdata == '0)
    else $error("bus or flags not idle after reset");
  wait_answer_a: assert property (
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("request not answered after one wait cycle");
  wait_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  wait_cause_a: assert property ($fell(avs_waitrequest) |-> $past(avs_read || avs_write))
    else $error("waitrequest dropped without a request");
  unmapped_zero_a: assert property (
    avs_read && avs_waitrequest && avs_address > mcct_pkg::OFS_FLAGS |=> avs_readdata == '0)
    else $error("unmapped read returned nonzero data");
  reserved_bit_a: assert property (
    avs_read && avs_waitrequest && avs_address == mcct_pkg::OFS_CTRL_A
    |=> avs_readdata[31:8] == '0 && !avs_readdata[2])
    else $error("control read shows reserved bits set");
  ovf_sticky_a: assert property (overflow_flag && !(clr && avs_writedata[0]) |=> overflow_flag)
    else $error("overflow flag dropped without a clear");
  cmp_sticky_a: assert property (
    compare_match_flag && !(clr && avs_writedata[1]) |=> compare_match_flag)
    else $error("compare flag dropped without a clear");
endmodule // mcct_timer_checker

bind mcct_timer mcct_timer_checker i_mcct_timer_checker (.clk(clk), .reset_n(reset_n),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .overflow_flag(overflow_flag), .compare_match_flag(compare_match_flag));
`default_nettype wire

// file: dv/tb_motor_capture_compare_timer.sv
// Testbench: register traffic, PWM bursts and capture line moves, checked by readback.
// Assumes the timer, the partner model and the bound checker are compiled first.
`timescale 1ns/10ps
`default_nettype none

module tb_motor_capture_compare_timer;
  localparam logic [5:0] CA = mcct_pkg::OFS_CTRL_A, CB = mcct_pkg::OFS_CTRL_B;
  localparam logic [5:0] CNT = mcct_pkg::OFS_CNT_LO, CMP = mcct_pkg::OFS_CMP_LO;
  localparam logic [5:0] CAP = mcct_pkg::OFS_CAPT_LO, FLG = mcct_pkg::OFS_FLAGS;
  logic clk = 1'b0, reset_n = 1'b0, rd = 1'b0, wr = 1'b0, go = 1'b0;
  logic wreq, pwm, busy, cmpf, en, ovf;
  logic [31:0] wdat = '0, rdat;
  logic [5:0] adr = '0;
  logic [3:0] be = 4'hF, lvl = '0, m;
  logic [7:0] npul = '0, d;
  logic [1:0] s, e;
  logic [15:0] a, b, ecap = '0;
  mcct_pkg::mcct_cap_in_s cap;
  int miscompares = 0, comparisons = 0, seed = 17953, n;

  always #10 clk = ~clk;

  mcct_timer i_mcct_timer (.clk(clk), .reset_n(reset_n), .avs_address(adr), .avs_read(rd),
    .avs_write(wr), .avs_writedata(wdat), .avs_byteenable(be), .avs_readdata(rdat),
    .avs_waitrequest(wreq), .pwm_period_signal(pwm), .cap_in(cap), .overflow_flag(ovf),
    .compare_match_flag(cmpf));
  mcct_hall_model i_mcct_hall_model (.clk(clk), .level(lvl), .pulses(npul), .go(go),
    .busy(busy), .cap_in(cap), .pwm(pwm));

  function automatic logic [15:0] cap_exp(input logic [1:0] ed, input logic [15:0] old,
                                          input logic [15:0] at_rise, input logic [15:0] at_fall);
    cap_exp = ed[1] ? at_fall : (ed[0] ? at_rise : old);
  endfunction

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Holds the request until waitrequest is sampled low, then idles one edge
  task automatic bus(input logic w, input logic [5:0] ad, input logic [7:0] dt);
    int k;
    k = 0;
    adr  <= ad;
    wdat <= {24'h0, dt};
    rd   <= !w;
    wr   <= w;
    do begin
      @(posedge clk);
      k++;
    end while (wreq !== 1'b0 && k < 40);
    d = rdat[7:0];
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk);
    if (k >= 40) begin
      miscompares++;
      $display("ERROR %0t bus timeout", $time);
    end
  endtask

  task automatic chk_reg(input logic [5:0] ad, input logic [7:0] ex);
    bus(1'b0, ad, 8'h00);
    check({8'h00, d}, {8'h00, ex});
  endtask

  task automatic chk16(input logic [5:0] ad, input logic [15:0] ex);
    chk_reg(ad, ex[7:0]);
    chk_reg(ad + 6'h04, ex[15:8]);
  endtask

  task automatic burst(input logic [7:0] cnt);
    npul <= cnt;
    go   <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    repeat (1100) begin
      @(posedge clk);
      if (!busy) break;
    end
    repeat (4) @(posedge clk);
  endtask

  task automatic move(input logic [3:0] l, input int cyc);
    lvl <= l;
    repeat (cyc) @(posedge clk);
  endtask

  task automatic give_verdict();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // Longest path is well under 30000 cycles
  initial begin
    repeat (30000) @(posedge clk);
    miscompares++;
    $display("ERROR %0t watchdog expired", $time);
    give_verdict();
  end

  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 10; i++) chk_reg(6'(4 * i), 8'h00);
    repeat (4) begin
      a = 16'($random(seed));
      bus(1'b1, CB, a[7:0]);
      chk_reg(CB, a[7:0]);
      bus(1'b1, CMP + 6'h04, a[15:8]);
      chk_reg(CMP + 6'h04, a[15:8]);
    end
    be <= 4'h0;
    bus(1'b1, CMP + 6'h04, ~a[15:8]);
    be <= 4'hF;
    bus(1'b1, CNT, 8'h5A);
    chk_reg(CNT, 8'h00);
    chk_reg(CMP + 6'h04, a[15:8]);
    bus(1'b1, CMP + 6'h04, 8'h00);
    bus(1'b1, CB, 8'h00);
    bus(1'b1, CA, 8'h74);
    chk_reg(CA, 8'h70);
    a = 16'(($random(seed) & 31) + 1);
    bus(1'b1, CA, 8'h08);
    burst(a[7:0]);
    chk16(CNT, a);
    bus(1'b1, CA, 8'h88);
    burst(8'h03);
    chk16(CNT, a);
    bus(1'b1, CA, 8'h08);
    burst(8'h02);
    chk16(CNT, a + 16'h2);
    bus(1'b1, CA, 8'h00);
    burst(8'h02);
    chk16(CNT, a + 16'h2);
    bus(1'b1, CA, 8'h08);
    chk16(CNT, 16'h0);
    bus(1'b1, FLG, 8'h03);
    bus(1'b1, CMP, a[7:0]);
    bus(1'b1, CB, 8'h01);
    burst(a[7:0]);
    check({15'h0, cmpf}, 16'h0);
    burst(8'h01);
    chk16(CNT, 16'h0);
    chk_reg(FLG, 8'h02);
    bus(1'b1, FLG, 8'h02);
    chk_reg(FLG, 8'h00);
    bus(1'b1, CMP, 8'h00);
    burst(8'h03);
    chk16(CNT, 16'h0);
    check({15'h0, cmpf}, 16'h1);
    bus(1'b1, CB, 8'h00);
    for (int i = 1; i < 8; i++) begin
      bus(1'b1, CA, 8'h00);
      bus(1'b1, CA, 8'(i * 16 + 8));
      repeat (4 << i) @(posedge clk);
      bus(1'b1, CA, 8'(i * 16 + 136));
      bus(1'b0, CNT, 8'h00);
      check(16'(d >= 8'h03 && d <= 8'h05), 16'h1);
    end
    // Selected line moves alone between other lines' moves, so a wrong source shows
    for (int k = 0; k < 17; k++) begin
      s  = 2'(k >> 2);
      e  = k[4] ? 2'h3 : 2'(k);
      en = !k[4];
      m  = 4'h8 >> s;
      bus(1'b1, CB, 8'h00);
      bus(1'b1, CA, {6'h00, s});
      bus(1'b1, CA, {6'h02, s});
      bus(1'b1, CB, {e, en, 5'h00});
      a = 16'(($random(seed) & 15) + 1);
      b = 16'(($random(seed) & 15) + 1);
      move(~m, 4);
      burst(a[7:0]);
      move(4'hF, 4);
      burst(b[7:0]);
      move(~m, 4);
      burst(8'h01);
      move(4'h0, 4);
      ecap = cap_exp(en ? e : 2'h0, ecap, a, a + b);
      chk16(CAP, ecap);
    end
    bus(1'b1, CA, 8'h03);
    bus(1'b1, CA, 8'h0B);
    bus(1'b1, CB, 8'h62);
    burst(8'h07);
    move(4'h1, 6);
    chk16(CAP, 16'h7);
    chk16(CNT, 16'h0);
    move(4'h0, 6);
    // A glitch of half the acceptance time must not capture; a long pulse must
    for (int f = 0; f < 4; f++) begin
      n = (f[1] ? 4 : 2) * (f[0] ? 4 : 1);
      bus(1'b1, CA, 8'h03);
      bus(1'b1, CA, 8'h0B);
      bus(1'b1, CB, {3'h3, 2'(f), 3'h4});
      burst(8'h05);
      move(4'h1, n / 2);
      move(4'h0, n + 8);
      burst(8'h01);
      move(4'h1, n + 8);
      move(4'h0, n + 8);
      chk16(CAP, 16'h6);
    end
    // No scenario gets near a wrap, so the overflow pin must never have risen
    check({15'h0, ovf}, 16'h0);
    give_verdict();
  end
endmodule // tb_motor_capture_compare_timer
`default_nettype wire

// file: shared/mcct_pkg.sv
// Shared constants and carriers of the motor capture/compare timer.
// Assumes one 50 MHz system clock and a 32-bit Avalon-MM register port.
`default_nettype none

package mcct_pkg;

  // ****************************************
  // Clock and widths
  // ****************************************
  localparam int CLK_MHZ   = 50;
  localparam int CNT_W     = 16;
  localparam int PRE_W     = 7;
  localparam int ADDR_W    = 6;
  localparam int DATA_W    = 32;
  localparam int FILT_LONG = 4;
  localparam int FILT_SHORT = 2;

  // ****************************************
  // Register byte offsets
  // ****************************************
  localparam logic [ADDR_W-1:0] OFS_CTRL_A   = 6'h00;
  localparam logic [ADDR_W-1:0] OFS_CTRL_B   = 6'h04;
  localparam logic [ADDR_W-1:0] OFS_CNT_LO   = 6'h08;
  localparam logic [ADDR_W-1:0] OFS_CNT_HI   = 6'h0C;
  localparam logic [ADDR_W-1:0] OFS_CMP_LO   = 6'h10;
  localparam logic [ADDR_W-1:0] OFS_CMP_HI   = 6'h14;
  localparam logic [ADDR_W-1:0] OFS_CAPT_LO  = 6'h18;
  localparam logic [ADDR_W-1:0] OFS_CAPT_HI  = 6'h1C;
  localparam logic [ADDR_W-1:0] OFS_FLAGS    = 6'h20;

  // Flag register bit positions, write one to clear
  localparam int FLAG_OVF_BIT = 0;
  localparam int FLAG_CMP_BIT = 1;

  // ****************************************
  // Field encodings
  // ****************************************
  localparam logic [2:0] CLK_SEL_PWM  = 3'h0;
  localparam logic [1:0] SRC_HALL_A   = 2'h0;
  localparam logic [1:0] SRC_HALL_B   = 2'h1;
  localparam logic [1:0] SRC_HALL_C   = 2'h2;
  localparam logic [1:0] SRC_EXT_PIN  = 2'h3;
  localparam logic [1:0] EDGE_OFF     = 2'h0;
  localparam logic [1:0] EDGE_RISE    = 2'h1;
  localparam logic [1:0] EDGE_FALL    = 2'h2;
  localparam logic [1:0] EDGE_BOTH    = 2'h3;
  localparam logic [1:0] FILT_DIV_END = 2'h3;

  localparam logic [7:0] CTRL_A_RST = 8'h00;
  localparam logic [7:0] CTRL_B_RST = 8'h00;

  // ****************************************
  // Carriers
  // ****************************************
  typedef struct packed {
    logic       counter_pause;
    logic [2:0] count_clock_select;
    logic       module_on;
    logic       reserved;
    logic [1:0] capture_source_select;
  } mcct_ctrl_a_s;

  typedef struct packed {
    logic [1:0] capture_edge_select;
    logic       capture_input_enable;
    logic       filter_sample_count;
    logic       filter_clock_select;
    logic       filter_enable;
    logic       capture_auto_clear;
    logic       compare_auto_clear;
  } mcct_ctrl_b_s;

  typedef struct packed {
    logic hall_input_a;
    logic hall_input_b;
    logic hall_input_c;
    logic external_capture_pin;
  } mcct_cap_in_s;

endpackage
`default_nettype wire
